// [design/irq_pkg.sv]
package irq_pkg;

  // Register byte addresses on the AXI4-Lite bus (printed offsets are not all multiples of four)
  localparam logic [7:0] idx_irq_enable_flag_primary = 8'h0B;
  localparam logic [7:0] idx_adc_irq_control         = 8'h1E;
  localparam logic [7:0] idx_sequencer_status        = 8'h20;
  localparam logic [9:0] addr_irq_enable_flag_primary = {idx_irq_enable_flag_primary, 2'b00};
  localparam logic [9:0] addr_adc_irq_control         = {idx_adc_irq_control, 2'b00};
  localparam logic [9:0] addr_sequencer_status        = {idx_sequencer_status, 2'b00};

  // Primary control register fields
  localparam int bit_global_irq_enable     = 0;
  localparam int bit_ext_irq_enable        = 1;
  localparam int bit_timer0_irq_enable     = 2;
  localparam int bit_timer1_irq_enable     = 3;
  localparam int bit_ext_irq_flag          = 4;
  localparam int bit_timer0_request_flag   = 5;
  localparam int bit_timer1_request_flag   = 6;
  localparam int bit_test_reserved         = 7;
  // Secondary control register fields
  localparam int bit_adc_irq_enable        = 0;
  localparam int bit_adc_request_flag      = 4;

  localparam logic [7:0] primary_reset   = 8'h00;
  localparam logic [7:0] secondary_reset = 8'h00;
  localparam logic [7:0] secondary_mask  = 8'h11;

  // Vector addresses
  localparam logic [10:0] vector_ext    = 11'h004;
  localparam logic [10:0] vector_timer0 = 11'h008;
  localparam logic [10:0] vector_timer1 = 11'h00C;
  localparam logic [10:0] vector_adc    = 11'h010;

  localparam logic [2:0] stack_depth = 3'h4;

  localparam logic [1:0] axi_okay   = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;

  // Build-time edge option for the external pin
  typedef enum logic [1:0]
  {
    edge_falling = 2'b00,
    edge_rising  = 2'b01,
    edge_both    = 2'b10
  } edge_mode_e;

  typedef enum logic [1:0]
  {
    seq_idle    = 2'b00,
    seq_ack     = 2'b01
  } seq_state_e;

  // Event inputs from the peripherals
  typedef struct packed
  {
    logic ext_pin;
    logic timer0_overflow;
    logic timer1_overflow;
    logic adc_done;
  } irq_sources_s;

  // Core sequencer handshake
  typedef struct packed
  {
    logic phase_two_pulse;
    logic return_from_irq;
    logic plain_return;
    logic low_power;
    logic [2:0] stack_pointer;
  } core_status_s;

  typedef struct packed
  {
    logic        vector_call;
    logic [10:0] vector_addr;
    logic        push_pc_only;
    logic        wake;
  } core_request_s;

endpackage

// [design/four_source_vectored_irq.sv]
// What this block does
// - Primary register bits 0-6: global, ext, timer0, timer1 enables; ext, timer0, timer1 flags.
// - Secondary register: ADC enable bit 0, ADC flag bit 4, other bits read zero.
// - With global enable clear, requests only set flags and are not acknowledged.
// - With the return stack full, no enabled request is acknowledged.
// - Every one of the four sources can wake the device from low power.
// - On acknowledge only the program counter is pushed, then the vector is called.
// - External flag set on a pin edge; falling, rising or both by build option.
// - External acknowledge calls 04H, clears external flag and global enable.
// - Timer 0 overflow sets flag; acknowledge calls 08H, clears flag and global enable.
// - Timer 1 as timer 0, flag in primary bit 6, vector 0CH.
// - ADC done sets flag; acknowledge calls 10H, clears flag and global enable.
// - In service, further acknowledges wait for return-from-interrupt or re-enable with stack room.
// - Return-from-interrupt sets global enable; plain return leaves it alone.
// - Requests between two phase-two pulses are taken on the later pulse.
// - Fixed priority: external, timer 0, timer 1, ADC.
// - A request flag stays set until serviced or cleared by software.
// - Wake from idle or halt on interrupt, port A fall, watchdog or timer overflow.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module four_source_vectored_irq
#(
  parameter irq_pkg::edge_mode_e edge_mode = irq_pkg::edge_falling
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [9:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [9:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire irq_pkg::irq_sources_s  sources,
  input  wire irq_pkg::core_status_s  core,
  input  wire logic                   port_a_fall,
  input  wire logic                   watchdog_overflow,
  output irq_pkg::core_request_s      request
);

  logic [7:0] primary;
  logic [7:0] secondary;
  logic       ext_pin_prev;
  logic       have_aw;
  logic       have_w;
  logic [9:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Four-entry request vector in priority order: ext, timer0, timer1, adc
  logic [3:0] flags;
  logic [3:0] enables;
  logic [3:0] pending;
  logic [3:0] grant;
  logic       stack_room;
  logic       take;
  logic       ext_edge;
  logic       wr_fire;
  logic       wr_primary;
  logic       wr_secondary;

  function automatic logic [3:0] pick_first(input logic [3:0] req);
    logic [3:0] g;
    g = 4'h0;
    if (req[0])
      g = 4'h1;
    else if (req[1])
      g = 4'h2;
    else if (req[2])
      g = 4'h4;
    else if (req[3])
      g = 4'h8;
    return g;
  endfunction

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  assign flags = {secondary[irq_pkg::bit_adc_request_flag],
                  primary[irq_pkg::bit_timer1_request_flag],
                  primary[irq_pkg::bit_timer0_request_flag],
                  primary[irq_pkg::bit_ext_irq_flag]};
  assign enables = {secondary[irq_pkg::bit_adc_irq_enable],
                    primary[irq_pkg::bit_timer1_irq_enable],
                    primary[irq_pkg::bit_timer0_irq_enable],
                    primary[irq_pkg::bit_ext_irq_enable]};
  assign stack_room = core.stack_pointer < irq_pkg::stack_depth;
  assign pending = flags & enables;
  // Global enable gates every acknowledge, so one routine cannot be re-entered unasked
  assign take = core.phase_two_pulse && primary[irq_pkg::bit_global_irq_enable]
                && stack_room && (pending != 4'h0);
  assign grant = take ? pick_first(pending) : 4'h0;

  always_comb
  begin
    case (edge_mode)
      irq_pkg::edge_falling: ext_edge = ext_pin_prev && !sources.ext_pin;
      irq_pkg::edge_rising:  ext_edge = !ext_pin_prev && sources.ext_pin;
      irq_pkg::edge_both:    ext_edge = ext_pin_prev != sources.ext_pin;
      default:               ext_edge = 1'b0;
    endcase
  end

  assign wr_fire = have_aw && have_w && !s_axi_bvalid;
  assign wr_primary = wr_fire && aw_addr == irq_pkg::addr_irq_enable_flag_primary && w_strb[0];
  assign wr_secondary = wr_fire && aw_addr == irq_pkg::addr_adc_irq_control && w_strb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_pin_prev <= 1'b1;
    else
      ext_pin_prev <= sources.ext_pin;
  end

  // Hardware set wins over both software clear and acknowledge clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      primary <= irq_pkg::primary_reset;
    else
    begin
      if (wr_primary)
        primary <= merge_byte(primary, w_data, w_strb);
      if (grant != 4'h0)
        primary[irq_pkg::bit_global_irq_enable] <= 1'b0;
      else if (core.return_from_irq)
        primary[irq_pkg::bit_global_irq_enable] <= 1'b1;
      if (grant[0])
        primary[irq_pkg::bit_ext_irq_flag] <= 1'b0;
      if (grant[1])
        primary[irq_pkg::bit_timer0_request_flag] <= 1'b0;
      if (grant[2])
        primary[irq_pkg::bit_timer1_request_flag] <= 1'b0;
      if (ext_edge)
        primary[irq_pkg::bit_ext_irq_flag] <= 1'b1;
      if (sources.timer0_overflow)
        primary[irq_pkg::bit_timer0_request_flag] <= 1'b1;
      if (sources.timer1_overflow)
        primary[irq_pkg::bit_timer1_request_flag] <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      secondary <= irq_pkg::secondary_reset;
    else
    begin
      if (wr_secondary)
        secondary <= merge_byte(secondary, w_data, w_strb) & irq_pkg::secondary_mask;
      if (grant[3])
        secondary[irq_pkg::bit_adc_request_flag] <= 1'b0;
      if (sources.adc_done)
        secondary[irq_pkg::bit_adc_request_flag] <= 1'b1;
    end
  end

  // Core call request: the core pushes only the program counter.
  // One process owns the whole request struct, so no field has a second driver.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      request.vector_call  <= 1'b0;
      request.vector_addr  <= 11'h000;
      request.push_pc_only <= 1'b0;
      request.wake         <= 1'b0;
    end
    else
    begin
      request.vector_call  <= grant != 4'h0;
      request.push_pc_only <= grant != 4'h0;
      case (grant)
        4'h1:    request.vector_addr <= irq_pkg::vector_ext;
        4'h2:    request.vector_addr <= irq_pkg::vector_timer0;
        4'h4:    request.vector_addr <= irq_pkg::vector_timer1;
        4'h8:    request.vector_addr <= irq_pkg::vector_adc;
        default: request.vector_addr <= request.vector_addr;
      endcase
      // Wake stays high while an enabled flag is pending; a lone source event, port A fall or watchdog pulse raises it for one cycle only
      request.wake <= core.low_power && (ext_edge || sources.timer0_overflow || sources.timer1_overflow
                      || sources.adc_done || pending != 4'h0 || port_a_fall || watchdog_overflow);
    end
  end

  // AXI4-Lite write path: address and data accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      aw_addr       <= 10'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irq_pkg::axi_okay;
    end
    else
    begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == irq_pkg::addr_irq_enable_flag_primary
                         || aw_addr == irq_pkg::addr_adc_irq_control) ? irq_pkg::axi_okay : irq_pkg::axi_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irq_pkg::axi_okay;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= irq_pkg::axi_okay;
        case (s_axi_araddr)
          irq_pkg::addr_irq_enable_flag_primary: s_axi_rdata <= {24'h00_0000, primary};
          irq_pkg::addr_adc_irq_control:         s_axi_rdata <= {24'h00_0000, secondary};
          irq_pkg::addr_sequencer_status:        s_axi_rdata <= {27'h000_0000, stack_room, pending};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= irq_pkg::axi_slverr;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [dv/irq_sva.sv]
`timescale 1ns/1ps
module irq_sva
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire irq_pkg::irq_sources_s  sources,
  input wire irq_pkg::core_status_s  core,
  input wire logic                   port_a_fall,
  input wire logic                   watchdog_overflow,
  input wire irq_pkg::core_request_s request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence vec_out;
    request.vector_call;
  endsequence
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  vec_pulse_a: assert property (vec_out |-> $past(core.phase_two_pulse))
    else $error("vector without phase two pulse");
  stack_room_a: assert property (vec_out |-> $past(core.stack_pointer) < 3'h4)
    else $error("vector with full stack");
  pc_push_a: assert property (request.push_pc_only == request.vector_call)
    else $error("push does not match vector call");
  vec_table_a: assert property (vec_out |-> request.vector_addr inside {11'h004, 11'h008, 11'h00c, 11'h010})
    else $error("vector address off table");
  service_hold_a: assert property (vec_out |=> !request.vector_call)
    else $error("second vector during service");
  wake_pin_a: assert property (core.low_power && (port_a_fall || watchdog_overflow) |=> request.wake)
    else $error("no wake on pin or watchdog");
  wake_src_a: assert property (core.low_power && (sources.timer1_overflow || sources.adc_done) |=> request.wake)
    else $error("no wake on source event");
  awake_quiet_a: assert property (!core.low_power |=> !request.wake)
    else $error("wake while running");
endmodule

bind four_source_vectored_irq irq_sva u_sva (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .sources, .core, .port_a_fall, .watchdog_overflow, .request);

// [dv/core_model.sv]
`timescale 1ns/1ps
module core_model
#(
  parameter int p2_period = 4
)
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire irq_pkg::core_request_s request,
  input  wire logic [1:0]             op,
  input  wire logic                   sleep,
  output irq_pkg::core_status_s       core
);
  // Op 1 is a subroutine call, 2 a plain return, 3 a return from interrupt
  int cnt;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 0;
      core <= '0;
    end
    else
    begin
      cnt <= (cnt == p2_period - 1) ? 0 : cnt + 1;
      core.phase_two_pulse <= (cnt == p2_period - 1);
      core.return_from_irq <= (op == 2'd3);
      core.plain_return <= (op == 2'd2);
      core.low_power <= sleep;
      // Only the return address goes on the stack, one entry per vector
      if (request.vector_call || op == 2'd1)
        core.stack_pointer <= core.stack_pointer + 3'h1;
      else if (op[1] && core.stack_pointer != 3'h0)
        core.stack_pointer <= core.stack_pointer - 3'h1;
    end
  end
endmodule

// [dv/four_source_vectored_irq_test.sv]
`timescale 1ns/1ps
module four_source_vectored_irq_test;
  localparam logic [9:0] prim = irq_pkg::addr_irq_enable_flag_primary;
  localparam logic [9:0] sec  = irq_pkg::addr_adc_irq_control;
  localparam logic [1:0] ok   = irq_pkg::axi_okay;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, port_a_fall = 1'b0, watchdog_overflow = 1'b0, sleep = 1'b0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, seed = 32'hca66_390e;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, op = '0;
  irq_pkg::irq_sources_s  sources = 4'b1000;
  irq_pkg::core_status_s  core;
  irq_pkg::core_request_s request;
  int n_mismatch = 0, comparisons = 0, cycles = 0, n_vec = 0;
  logic [33:0] exp_rd[$];
  logic [10:0] exp_vec[$];
  always #25 aclk = ~aclk;
  four_source_vectored_irq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sources(sources), .core(core),
    .port_a_fall(port_a_fall), .watchdog_overflow(watchdog_overflow), .request(request));
  core_model u_core (.aclk(aclk), .aresetn(aresetn), .request(request), .op(op), .sleep(sleep), .core(core));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] resp);
    logic done_aw, done_w;
    done_aw = 1'b0;
    done_w = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(done_aw && done_w))
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      done_aw |= (awready === 1'b1);
      done_w |= (wready === 1'b1);
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", resp, bresp);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] exp);
    exp_rd.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Flips the chosen source lines for one cycle; the pin bit gives a fall then a rise
  task automatic ev(input logic [3:0] m);
    sources <= sources ^ m;
    @(posedge aclk);
    sources <= sources ^ m;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (rvalid === 1'b1 && rready === 1'b1)
      chk("rdata", exp_rd.size() ? exp_rd.pop_front() : '1, {rresp, rdata});
    if (request.vector_call === 1'b1)
    begin
      n_vec++;
      chk("vector_addr", exp_vec.size() ? exp_vec.pop_front() : '1, request.vector_addr);
    end
    if (cycles == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    tick(3);
    aresetn <= 1'b1;
    tick(1);
    rd(prim, 34'h0);
    rd(sec, 34'h0);
    rd(10'h3fc, {irq_pkg::axi_slverr, 32'h0});
    wr(10'h3fc, 8'h5a, irq_pkg::axi_slverr);
    $display("test reset and unmapped done");
    repeat (4)
    begin
      seed = xorshift(seed);
      wr(prim, seed[7:0] & 8'h0e, ok);
      rd(prim, {26'h0, seed[7:0] & 8'h0e});
    end
    wr(sec, 8'hef, ok);
    rd(sec, 34'h1);
    $display("test register fields done");
    wr(prim, 8'h0e, ok);
    ev(4'b1111);
    tick(12);
    rd(prim, 34'h7e);
    rd(sec, 34'h11);
    $display("test flags held done");
    exp_vec = {irq_pkg::vector_ext, irq_pkg::vector_timer0, irq_pkg::vector_timer1, irq_pkg::vector_adc};
    wr(prim, 8'h7f, ok);
    while (n_vec < 1) @(posedge aclk);
    rd(prim, 34'h6e);
    op <= 2'd2;
    tick(1);
    op <= 2'd0;
    tick(8);
    rd(prim, 34'h6e);
    for (int i = 2; i <= 5; i++)
    begin
      op <= 2'd3;
      tick(1);
      op <= 2'd0;
      while (i < 5 && n_vec < i) @(posedge aclk);
    end
    tick(4);
    rd(prim, 34'h0f);
    rd(sec, 34'h01);
    $display("test priority and vectors done");
    // Fill the stack so that an enabled request must wait for room
    // Calls are made outside any service routine, never inside one
    repeat (4)
    begin
      op <= 2'd1;
      tick(1);
    end
    op <= 2'd0;
    ev(4'b0100);
    tick(12);
    exp_vec.push_back(irq_pkg::vector_timer0);
    op <= 2'd2;
    tick(1);
    op <= 2'd0;
    while (n_vec < 5) @(posedge aclk);
    $display("test stack full done");
    wr(prim, 8'h00, ok);
    sleep <= 1'b1;
    tick(3);
    chk("wake", 34'h0, request.wake);
    for (int k = 0; k < 3; k++)
    begin
      tick(4);
      port_a_fall <= (k == 0);
      watchdog_overflow <= (k == 1);
      sources.adc_done <= (k == 2);
      tick(1);
      port_a_fall <= 1'b0;
      watchdog_overflow <= 1'b0;
      sources.adc_done <= 1'b0;
      tick(1);
      chk("wake", 34'h1, request.wake);
    end
    $display("test wake done");
    results();
  end
endmodule
